// *** hdl/sisr_top.sv ***
// Function
// - Writing one to bit 7 of setup register resets the whole chip and registers.
// - The reset bit clears itself, so it always reads back zero.
// - The soft reset sequence completes within 750 ns of the write.
// - Bit 5 selects streaming address decrement (0) or increment (1); resets to 1.
// - Bit 4 always reads one; read data always leaves on the serial output.
// - Setup register at address 0x0 holds 0x30 after power-up or reset.
// - Address-freeze bit in register 0x10 holds the streaming address fixed.
`default_nettype none
module sisr_top
    import sisr_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_sclk,
    input  wire logic        spi_sdi,
    output logic             spi_sdo,
    output logic             spi_sdo_oe,
    output logic             chip_reset_n,
    output logic             addr_ascend,
    output logic             addr_hold
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    sisr_pins_t meta_r, sync_r, prev_r;
    sisr_pins_t pins_in;

    assign pins_in = '{cs_n: spi_cs_n, sclk: spi_sclk, sdi: spi_sdi};

    always_ff @(posedge clock) begin
        if (!resetn) begin
            meta_r <= '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
            sync_r <= '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
            prev_r <= '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
        end else begin
            meta_r <= pins_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    logic rise;
    logic fall;
    logic sel;

    // Each sclk phase spans several clocks, so edges are found from the synchronised copy alone.
    assign sel  = !sync_r.cs_n;
    assign rise = sel && sync_r.sclk && !prev_r.sclk;
    assign fall = sel && !sync_r.sclk && prev_r.sclk;

    // ****************************************
    // Transaction engine
    // ****************************************
    // Unmapped addresses read zero, so a host scanning the map never sees a stale shift value.
    function automatic logic [7:0] read_mux(input logic [14:0] a, input logic [7:0] setup, input logic [7:0] ucfg);
        logic [7:0] v;
        v = 8'h00;
        if (a == SETUP_ADDR) begin
            v = setup;
            v[SOFT_RESET_BIT] = 1'b0;
            v[OUT_IND_BIT] = 1'b1;
        end else if (a == USER_CFG_ADDR) begin
            v = ucfg;
        end
        return v;
    endfunction

    // The freeze bit wins over the direction bit, so one location can be filled or drained in one frame.
    function automatic logic [14:0] step_addr(input logic [14:0] a, input logic hold, input logic up);
        logic [14:0] n;
        n = a;
        if (hold) begin
            n = a;
        end else if (up) begin
            n = a + 15'h0001;
        end else begin
            n = a - 15'h0001;
        end
        return n;
    endfunction

    sisr_state_t state_r, state_nxt;
    logic [3:0]  cnt_r, cnt_nxt;
    logic        rw_r, rw_nxt;
    logic [14:0] addr_r, addr_nxt;
    logic [7:0]  sh_r, sh_nxt;
    logic [7:0]  setup_r, setup_nxt;
    logic [7:0]  ucfg_r, ucfg_nxt;
    logic [5:0]  rcnt_r, rcnt_nxt;
    logic        sdo_r, sdo_nxt;
    logic        oe_r, oe_nxt;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        rw_nxt    = rw_r;
        addr_nxt  = addr_r;
        sh_nxt    = sh_r;
        setup_nxt = setup_r;
        ucfg_nxt  = ucfg_r;
        rcnt_nxt  = rcnt_r;
        sdo_nxt   = sdo_r;
        oe_nxt    = sel && rw_r && (state_r == ST_DATA);
        case (state_r)
            ST_IDLE: begin
                cnt_nxt = 4'h0;
                if (sel) begin
                    state_nxt = ST_CMD;
                end
            end
            ST_CMD: begin
                if (!sel) begin
                    state_nxt = ST_IDLE;
                end else if (rise) begin
                    if (cnt_r == 4'h0) begin
                        rw_nxt = sync_r.sdi;
                    end else begin
                        addr_nxt = {addr_r[13:0], sync_r.sdi};
                    end
                    cnt_nxt = cnt_r + 4'h1;
                    if (cnt_r == 4'hF) begin
                        state_nxt = ST_DATA;
                        cnt_nxt   = 4'h0;
                        sh_nxt    = read_mux({addr_r[13:0], sync_r.sdi}, setup_r, ucfg_r);
                    end
                end
            end
            ST_DATA: begin
                if (!sel) begin
                    state_nxt = ST_IDLE;
                end else if (fall && rw_r) begin
                    sdo_nxt = sh_r[7];
                    sh_nxt  = {sh_r[6:0], 1'b0};
                end else if (rise) begin
                    if (!rw_r) begin
                        sh_nxt = {sh_r[6:0], sync_r.sdi};
                    end
                    cnt_nxt = {1'b0, cnt_r[2:0] + 3'h1};
                    if (cnt_r[2:0] == 3'h7) begin
                        cnt_nxt = 4'h0;
                        addr_nxt = step_addr(addr_r, ucfg_r[ADDR_HOLD_BIT], setup_r[ASCEND_BIT]);
                        if (!rw_r && addr_r == SETUP_ADDR) begin
                            // Only writable bits change; the indicator stays one.
                            setup_nxt = ({sh_r[6:0], sync_r.sdi} & SETUP_WMASK) | 8'h10;
                            // The reset bit was the first data bit and now sits in bit 6 of the shifter.
                            if (sh_r[6] == 1'b1) begin
                                state_nxt = ST_RST;
                                rcnt_nxt  = RST_CYCLES;
                            end
                        end else if (!rw_r && addr_r == USER_CFG_ADDR) begin
                            ucfg_nxt = {sh_r[6:0], sync_r.sdi};
                        end
                        if (rw_r) begin
                            sh_nxt = read_mux(addr_nxt, setup_r, ucfg_r);
                        end
                    end
                end
            end
            ST_RST: begin
                // Host traffic here is ignored; the host must stay quiet meanwhile.
                setup_nxt = SETUP_RESET;
                ucfg_nxt  = USER_CFG_RESET;
                sdo_nxt   = 1'b0;
                oe_nxt    = 1'b0;
                rcnt_nxt  = rcnt_r - 6'h01;
                if (rcnt_r == 6'h01) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            cnt_r   <= 4'h0;
            rw_r    <= 1'b0;
            addr_r  <= 15'h0000;
            sh_r    <= 8'h00;
            setup_r <= SETUP_RESET;
            ucfg_r  <= USER_CFG_RESET;
            rcnt_r  <= 6'h00;
            sdo_r   <= 1'b0;
            oe_r    <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            rw_r    <= rw_nxt;
            addr_r  <= addr_nxt;
            sh_r    <= sh_nxt;
            setup_r <= setup_nxt;
            ucfg_r  <= ucfg_nxt;
            rcnt_r  <= rcnt_nxt;
            sdo_r   <= sdo_nxt;
            oe_r    <= oe_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign spi_sdo      = sdo_r;
    assign spi_sdo_oe   = oe_r;
    assign chip_reset_n = (state_r != ST_RST);
    assign addr_ascend  = setup_r[ASCEND_BIT];
    assign addr_hold    = ucfg_r[ADDR_HOLD_BIT];

endmodule
`default_nettype wire

// *** shared/sisr_pkg.sv ***
`default_nettype none
package sisr_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [14:0] SETUP_ADDR      = 15'h0000;
    localparam logic [14:0] USER_CFG_ADDR   = 15'h0010;
    localparam logic [7:0]  SETUP_RESET     = 8'h30;
    localparam logic [7:0]  USER_CFG_RESET  = 8'h00;
    localparam int          SOFT_RESET_BIT  = 7;
    localparam int          ASCEND_BIT      = 5;
    localparam int          OUT_IND_BIT     = 4;
    localparam int          ADDR_HOLD_BIT   = 0;
    localparam logic [7:0]  SETUP_WMASK     = 8'h6F;

    // ****************************************
    // Timing
    // ****************************************
    localparam int          CLK_HZ          = 20000000;
    localparam int          RST_TIME_NS     = 750;
    localparam int          RST_CYC_CALC    = (RST_TIME_NS * (CLK_HZ / 1000000)) / 1000;
    localparam logic [5:0]  RST_CYCLES      = 6'((RST_CYC_CALC < 1) ? 1 : RST_CYC_CALC);

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic sdi;
    } sisr_pins_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CMD  = 4'b0010,
        ST_DATA = 4'b0100,
        ST_RST  = 4'b1000
    } sisr_state_t;

endpackage
`default_nettype wire

// *** testbench/sisr_monitor.sv ***
`default_nettype none
module sisr_monitor
    import sisr_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_sdi,
    input wire logic spi_sdo,
    input wire logic spi_sdo_oe,
    input wire logic chip_reset_n,
    input wire logic addr_ascend,
    input wire logic addr_hold
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    a_reset_values: assert property ($rose(resetn) |-> addr_ascend && !addr_hold && chip_reset_n)
        else $error("Wrong values after reset.");
    a_soft_bound: assert property ($fell(chip_reset_n) |-> ##[1:15] chip_reset_n)
        else $error("Soft reset ran too long.");
    a_soft_restore: assert property ($rose(chip_reset_n) |-> addr_ascend && !addr_hold)
        else $error("Soft reset left stale settings.");
    a_self_clear: assert property ($rose(chip_reset_n) |-> chip_reset_n [*8])
        else $error("Soft reset retriggered.");
    a_soft_frame: assert property ($fell(chip_reset_n) |-> !$past(spi_cs_n, 2))
        else $error("Soft reset began outside a frame.");
    a_idle_quiet: assert property (spi_cs_n [*8] |-> !spi_sdo_oe)
        else $error("Output driven while deselected.");
    a_reset_quiet: assert property (!chip_reset_n |-> !spi_sdo_oe)
        else $error("Output driven during soft reset.");
    a_cfg_stable: assert property ((spi_cs_n && chip_reset_n) [*6] |-> $stable(addr_ascend) && $stable(addr_hold))
        else $error("Settings changed while idle.");
    a_sdo_shift: assert property ($changed(spi_sdo) && chip_reset_n |-> $past(spi_sclk, 4) && !$past(spi_sclk, 3))
        else $error("Serial output moved away from a falling clock edge.");
endmodule
bind sisr_top sisr_monitor mon (.clock(clock), .resetn(resetn), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .chip_reset_n(chip_reset_n),
    .addr_ascend(addr_ascend), .addr_hold(addr_hold));
`default_nettype wire

// *** testbench/sisr_host.sv ***
`default_nettype none
module sisr_host (
    input  wire logic clock,
    input  wire logic sdo,
    output var logic  cs_n,
    output var logic  sclk,
    output var logic  sdi
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // Sclk stands still between frames and sdi is inverted once released.
    task automatic xfer(input logic rw, input logic [14:0] a, input logic [15:0] wd, input int nb,
                        output logic [15:0] q);
        logic [31:0] sh;
        sh = {rw, a, wd};
        q = 16'h0000;
        @(negedge clock);
        cs_n = 1'b0;
        for (int i = 0; i < 16 + 8 * nb; i++) begin
            sdi = sh[31 - i];
            repeat (4) @(negedge clock);
            sclk = 1'b1;
            repeat (4) @(negedge clock);
            q = {q[14:0], sdo};
            sclk = 1'b0;
        end
        repeat (4) @(negedge clock);
        cs_n = 1'b1;
        sdi = ~sdi;
        repeat (8) @(negedge clock);
    endtask
endmodule
`default_nettype wire

// *** testbench/test_spi_interface_setup_register.sv ***
`default_nettype none
module test_spi_interface_setup_register;
    import sisr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock, resetn, cs_n, sclk, sdi, sdo, crst_n, asc, hold;
    logic [15:0] q;
    int          n_errors, checks_done, setup, ucfg, d;
    sisr_top uut (.clock(clock), .resetn(resetn), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_sdi(sdi), .spi_sdo(sdo),
        .spi_sdo_oe(), .chip_reset_n(crst_n), .addr_ascend(asc), .addr_hold(hold));
    sisr_host host (.clock(clock), .sdo(sdo), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    function automatic int model(input int a);
        return (a == 0) ? setup : (a == 16) ? ucfg : 0;
    endfunction
    task automatic wr(input int a, input int v);
        host.xfer(1'b0, 15'(a), {8'(v), 8'h00}, 1, q);
        if (a == 16) ucfg = v;
        if (a == 0 && v < 8'h80) setup = (v & 8'h6F) | 8'h10;
        if (a == 0 && v >= 8'h80) begin
            setup = 8'h30;
            ucfg = 0;
            check(8'(crst_n), 8'h00);
            repeat (8) @(negedge clock);
            check(8'(crst_n), 8'h01);
        end
        check(8'(asc), 8'((setup >> 5) & 1));
        check(8'(hold), 8'(ucfg & 1));
    endtask
    task automatic rd(input int a, input int nb);
        int x;
        host.xfer(1'b1, 15'(a), 16'h0000, nb, q);
        x = a;
        for (int i = nb - 1; i >= 0; i--) begin
            check(q[8 * i +: 8], 8'(model(x)));
            x = (ucfg & 1) ? x : (setup & 8'h20) ? x + 1 : x - 1;
        end
    endtask
    initial begin
        resetn = 1'b0;
        n_errors = 0;
        checks_done = 0;
        setup = 8'h30;
        ucfg = 0;
        void'($urandom(32'h09E314CE));
        repeat (10) @(negedge clock);
        resetn = 1'b1;
        repeat (4) @(negedge clock);
        rd(0, 1);
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            d = ($urandom & 8'h5F) | ((k & 1) * 8'h20);
            wr(0, d);
            rd(0, 1);
            wr(16, $urandom & 8'hFE);
            rd(15, 2);
            rd(17, 2);
        end
        $display("test registers done");
        wr(16, 8'h01 | $urandom);
        rd(16, 2);
        rd(15, 2);
        $display("test hold done");
        wr(0, 8'h80 | $urandom);
        rd(0, 1);
        rd(16, 1);
        $display("test soft reset done");
        test_done();
    end
    // Whole run needs about 310 us; the limit leaves ample room.
    initial begin
        #2000000;
        n_errors++;
        test_done();
    end
endmodule
`default_nettype wire
